// *** src/cie_pkg.sv ***
// Purpose: Constants and types for the CAN interrupt enable block
// Assumes: Avalon-MM slave with 32-bit data, word aligned registers
// Notes: Functional notes below
package cie_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h0;
	localparam logic [3:0] ADDR_STATUS = 4'h4;
	localparam logic [3:0] ADDR_FLAGS = 4'h8;

	// Field positions in bus_irq_enable_reg
	localparam int WAKE_IRQ_EN_BIT = 7;
	localparam int STATE_CHANGE_IRQ_EN_BIT = 6;
	localparam int RX_SENS_LSB = 4;
	localparam int TX_SENS_LSB = 2;
	localparam int OVERRUN_IRQ_EN_BIT = 1;
	localparam int RX_FULL_IRQ_EN_BIT = 0;

	// Flag register bit positions (write one to clear)
	localparam int FLAG_WAKE_BIT = 0;
	localparam int FLAG_STATE_CHANGE_BIT = 1;
	localparam int FLAG_OVERRUN_BIT = 2;
	localparam int FLAG_RX_FULL_BIT = 3;

	// Status register positions
	localparam int STAT_RX_LSB = 0;
	localparam int STAT_TX_LSB = 2;
	localparam int STAT_INIT_BIT = 4;

	localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Sensitivity codes
	localparam logic [1:0] SENS_NONE = 2'h0;
	localparam logic [1:0] SENS_BUSOFF = 2'h1;
	localparam logic [1:0] SENS_ERROR = 2'h2;
	localparam logic [1:0] SENS_ALL = 2'h3;

	// Bus state codes; receiver and transmitter share all four, bus-off included
	typedef enum logic [1:0] {
		CIE_ST_OK = 2'h0,
		CIE_ST_WARN = 2'h1,
		CIE_ST_ERR = 2'h2,
		CIE_ST_BUSOFF = 2'h3
	} cie_bus_state_t;

	// Enable register layout
	typedef struct packed {
		logic wake_irq_en;
		logic state_change_irq_en;
		logic [1:0] rx_state_sensitivity;
		logic [1:0] tx_state_sensitivity;
		logic overrun_irq_en;
		logic rx_full_irq_en;
	} cie_enable_t;

	// Event flags
	typedef struct packed {
		logic rx_full;
		logic overrun;
		logic state_change_flag;
		logic wake;
	} cie_flags_t;

	// Interrupt request outputs
	typedef struct packed {
		logic wake_irq;
		logic error_irq;
		logic rx_irq;
	} cie_irq_t;

endpackage : cie_pkg

// *** src/cie_irq_enable.sv ***
// Purpose: CAN interrupt enable and state-change sensitivity logic
// Assumes: Events are one-cycle pulses synchronous to core_clk
// Notes: Flags clear by writing one; a set in the same cycle wins
`timescale 1ns/1ps
module cie_irq_enable (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic init_request,
	input wire logic init_ack,
	input wire logic wake_event,
	input wire logic overrun_event,
	input wire logic rx_full_event,
	input wire logic [1:0] rx_bus_state,
	input wire logic [1:0] tx_bus_state,
	output logic [1:0] rx_state_flags,
	output logic [1:0] tx_state_flags,
	output logic wake_irq,
	output logic error_irq,
	output logic rx_irq
);

	// ------------------------------------------------------------
	// Reset release
	// ------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_n_q;

	// Two-stage release so all logic leaves reset on one edge
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_meta_q <= 1'b0;
			rst_sync_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_n_q <= rst_meta_q;
		end
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Does a state change matter at the chosen sensitivity
	function automatic logic cie_change_hit(input logic [1:0] sens,
			input logic [1:0] old_st, input logic [1:0] new_st);
		logic hit;
		hit = 1'b0;
		if (old_st != new_st) begin
			unique case (sens)
				cie_pkg::SENS_NONE: hit = 1'b0;
				cie_pkg::SENS_BUSOFF: hit = (old_st == cie_pkg::CIE_ST_BUSOFF) ||
						(new_st == cie_pkg::CIE_ST_BUSOFF);
				cie_pkg::SENS_ERROR: hit = (old_st >= cie_pkg::CIE_ST_ERR) ||
						(new_st >= cie_pkg::CIE_ST_ERR);
				cie_pkg::SENS_ALL: hit = 1'b1;
			endcase
		end
		return hit;
	endfunction : cie_change_hit

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	cie_pkg::cie_enable_t en_q, en_d;
	cie_pkg::cie_flags_t flags_q, flags_d;
	logic [1:0] rx_st_q, rx_st_d;
	logic [1:0] tx_st_q, tx_st_d;
	logic [31:0] rdata_q, rdata_d;
	logic rd_done_q, rd_done_d;
	cie_pkg::cie_irq_t irq;

	logic init_mode;
	logic init_free;
	logic wr_en;
	logic wr_flags;
	logic [1:0] rx_eff;
	logic rx_hit;
	logic tx_hit;

	assign init_mode = init_request && init_ack;
	assign init_free = !init_request && !init_ack;
	assign wr_en = avs_write && avs_byteenable[0] &&
			(avs_address == cie_pkg::ADDR_IRQ_ENABLE);
	assign wr_flags = avs_write && avs_byteenable[0] &&
			(avs_address == cie_pkg::ADDR_FLAGS);

	// Tx going from bus-off straight to ok drags the receiver to ok as well
	assign rx_eff = (tx_st_q == cie_pkg::CIE_ST_BUSOFF &&
			tx_bus_state == cie_pkg::CIE_ST_OK) ? cie_pkg::CIE_ST_OK : rx_bus_state;
	assign rx_hit = cie_change_hit(en_q.rx_state_sensitivity, rx_st_q, rx_eff);
	assign tx_hit = cie_change_hit(en_q.tx_state_sensitivity, tx_st_q, tx_bus_state);

	// Enable register next value
	always_comb begin
		en_d = en_q;
		if (init_mode) begin
			en_d = cie_pkg::IRQ_ENABLE_RESET;
			en_d.rx_state_sensitivity = en_q.rx_state_sensitivity;
			en_d.tx_state_sensitivity = en_q.tx_state_sensitivity;
		end else if (wr_en && init_free) begin
			en_d = avs_writedata[7:0];
		end
	end

	// Flags and tracked states; events beat clears
	always_comb begin
		flags_d = flags_q;
		rx_st_d = rx_st_q;
		tx_st_d = tx_st_q;
		if (wr_flags) begin
			flags_d = flags_q & ~cie_pkg::cie_flags_t'(avs_writedata[3:0]);
		end
		// States only move while no change is pending
		if (!flags_q.state_change_flag) begin
			rx_st_d = rx_eff;
			tx_st_d = tx_bus_state;
			if (rx_hit || tx_hit) begin
				flags_d.state_change_flag = 1'b1;
			end
		end
		if (wake_event) begin
			flags_d.wake = 1'b1;
		end
		if (overrun_event) begin
			flags_d.overrun = 1'b1;
		end
		if (rx_full_event) begin
			flags_d.rx_full = 1'b1;
		end
	end

	// Read data, one wait cycle on reads
	always_comb begin
		rdata_d = rdata_q;
		rd_done_d = 1'b0;
		if (avs_read && !rd_done_q) begin
			rd_done_d = 1'b1;
			unique case (avs_address)
				cie_pkg::ADDR_IRQ_ENABLE: rdata_d = {24'h00_0000, en_q};
				cie_pkg::ADDR_STATUS: rdata_d = {27'h000_0000, init_mode,
						tx_st_q, rx_st_q};
				cie_pkg::ADDR_FLAGS: rdata_d = {28'h000_0000, flags_q};
				default: rdata_d = cie_pkg::UNMAPPED_READ;
			endcase
		end
	end

	// Register everything
	always_ff @(posedge core_clk or negedge rst_sync_n_q) begin
		if (!rst_sync_n_q) begin
			en_q <= cie_pkg::IRQ_ENABLE_RESET;
			flags_q <= '0;
			rx_st_q <= cie_pkg::CIE_ST_OK;
			tx_st_q <= cie_pkg::CIE_ST_OK;
			rdata_q <= cie_pkg::UNMAPPED_READ;
			rd_done_q <= 1'b0;
		end else begin
			en_q <= en_d;
			flags_q <= flags_d;
			rx_st_q <= rx_st_d;
			tx_st_q <= tx_st_d;
			rdata_q <= rdata_d;
			rd_done_q <= rd_done_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Gated requests, level while flag and enable both set
	assign irq.wake_irq = flags_q.wake && en_q.wake_irq_en;
	assign irq.error_irq = (flags_q.state_change_flag && en_q.state_change_irq_en) ||
			(flags_q.overrun && en_q.overrun_irq_en);
	assign irq.rx_irq = flags_q.rx_full && en_q.rx_full_irq_en;
	assign wake_irq = irq.wake_irq;
	assign error_irq = irq.error_irq;
	assign rx_irq = irq.rx_irq;
	assign rx_state_flags = rx_st_q;
	assign tx_state_flags = tx_st_q;
	assign avs_readdata = rdata_q;
	// Writes finish at once; reads wait one cycle for data
	assign avs_waitrequest = avs_read && !rd_done_q;

endmodule : cie_irq_enable

// *** verif/cie_irq_enable_checker.sv ***
// Purpose: Port checks for the CAN interrupt enable block
// Assumes: Bound to every cie_irq_enable instance
// Notes: Rx and error request rises are traced back to an event or a bus write, error rises also to a bus state change; rx falls to a write or init mode
`timescale 1ns/1ps
module cie_irq_enable_checker (
	input wire logic core_clk, resetn, avs_read, avs_write, avs_waitrequest,
	input wire logic init_request, init_ack, overrun_event, rx_full_event,
	input wire logic [1:0] rx_bus_state, tx_bus_state, rx_state_flags, tx_state_flags,
	input wire logic wake_irq, error_irq, rx_irq
);
	// One clock domain, so one default for all properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	property p_rdw; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
	a_rdw: assert property (p_rdw) else $error("read stalled past one cycle");
	property p_wrw; avs_write |-> !avs_waitrequest; endproperty
	a_wrw: assert property (p_wrw) else $error("write stalled");
	property p_init; (init_request && init_ack) [*2] |-> !(wake_irq || error_irq || rx_irq);
	endproperty
	a_init: assert property (p_init) else $error("request during init mode");
	property p_rxr; $rose(rx_irq) |-> $past(rx_full_event || avs_write); endproperty
	a_rxr: assert property (p_rxr) else $error("rx request without cause");
	property p_err; $rose(error_irq) |-> $past(overrun_event || avs_write
		|| rx_bus_state != rx_state_flags || tx_bus_state != tx_state_flags); endproperty
	a_err: assert property (p_err) else $error("error request without cause");
	property p_rxf; $fell(rx_irq) |-> $past(avs_write || init_request && init_ack); endproperty
	a_rxf: assert property (p_rxf) else $error("rx request dropped alone");
	property p_rxt; $changed(rx_state_flags) |->
		rx_state_flags == $past(rx_bus_state) || rx_state_flags == 2'h0; endproperty
	a_rxt: assert property (p_rxt) else $error("rx flags off bus state");
	property p_txt; $changed(tx_state_flags) |-> tx_state_flags == $past(tx_bus_state);
	endproperty
	a_txt: assert property (p_txt) else $error("tx flags off bus state");
	// Main scenarios reached
	c_rx: cover property (rx_irq);
	c_err: cover property (error_irq && tx_state_flags == 2'h3);
	c_init: cover property (init_request && init_ack && avs_write);
endmodule : cie_irq_enable_checker

bind cie_irq_enable cie_irq_enable_checker chk (.*);

// *** verif/cie_irq_enable_tb.sv ***
// Purpose: Directed bench for the CAN interrupt enable block
// Assumes: Reads answer after one wait cycle, writes at once
// Notes: Bus waits are bounded; a stuck access counts as a mismatch
`timescale 1ns/1ps
module cie_irq_enable_tb;
	logic core_clk = 0, resetn = 0, rd = 0, wr = 0, ir = 0, ia = 0;
	logic we = 0, oe = 0, fe = 0, wt, x;
	logic [3:0] ad = 0;
	logic [31:0] wd = 0, rdat, q;
	logic [1:0] rs = 0, ts = 0, rf, tf;
	cie_pkg::cie_irq_t irq;
	int errors = 0, compares = 0;
	// Clock at 40 MHz
	always #12.5 core_clk = ~core_clk;
	// Byte lane 0 only; upper lanes carry nothing
	cie_irq_enable uut (.core_clk(core_clk), .resetn(resetn), .avs_address(ad),
		.avs_read(rd), .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'h1),
		.avs_readdata(rdat), .avs_waitrequest(wt), .init_request(ir), .init_ack(ia),
		.wake_event(we), .overrun_event(oe), .rx_full_event(fe), .rx_bus_state(rs),
		.tx_bus_state(ts), .rx_state_flags(rf), .tx_state_flags(tf),
		.wake_irq(irq.wake_irq), .error_irq(irq.error_irq), .rx_irq(irq.rx_irq));
	// Verdict and end of run
	task automatic stop_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			errors++;
			$display("ERROR t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Request level compare
	task automatic ci(input logic [2:0] e);
		chk({29'h0, irq}, {29'h0, e});
	endtask : ci
	task automatic w(input int n);
		repeat (n) @(posedge core_clk);
	endtask : w
	// Avalon access; held until waitrequest is seen low at an edge
	// Settled values are looked at mid-cycle, so the edge holds the same
	task automatic acc(input logic iw, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		rd <= !iw;
		wr <= iw;
		ad <= a;
		wd <= d;
		@(negedge core_clk);
		while (wt !== 1'b0 && n < 20) begin
			@(negedge core_clk);
			n++;
		end
		q = rdat;
		@(posedge core_clk);
		rd <= 0;
		wr <= 0;
		if (n >= 20) errors++;
	endtask : acc
	task automatic rc(input logic [3:0] a, input logic [31:0] e);
		acc(0, a, 32'h0);
		chk(q, e);
	endtask : rc
	// One-cycle event pulses
	task automatic pl(input logic [2:0] m);
		@(posedge core_clk);
		{we, oe, fe} <= m;
		@(posedge core_clk);
		{we, oe, fe} <= 3'h0;
	endtask : pl
	// Hang guard at 4000 cycles, far beyond the few hundred needed
	initial begin
		#100us;
		errors++;
		stop_test();
	end
	initial begin
		w(10);
		resetn <= 1;
		w(3);
		rc(4'h0, 32'h0);
		rc(4'hC, 32'h0);
		acc(1, 4'h0, 32'h0000_00C3);
		rc(4'h0, 32'h0000_00C3);
		pl(3'h7); w(2);
		ci(3'h7);
		rc(4'h8, 32'h0000_000D);
		acc(1, 4'h8, 32'h0000_000F); w(2);
		ci(3'h0);
		acc(1, 4'h0, 32'h0000_003C);
		pl(3'h7); w(2);
		ci(3'h0);
		$display("test enables done");
		acc(1, 4'h0, 32'h0000_00FF);
		ir <= 1; ia <= 1; w(3);
		rc(4'h0, 32'h0000_003C);
		ci(3'h0);
		acc(1, 4'h0, 32'h0);
		rc(4'h0, 32'h0000_003C);
		ir <= 0; ia <= 0; w(2);
		acc(1, 4'h8, 32'h0000_000F);
		$display("test init done");
		// Each code against bus-off, error and plain transitions
		for (int s = 0; s < 2; s++) for (int c = 0; c < 4; c++) begin
			for (int t = 0; t < 3; t++) begin
				// Bus-off code: only 2 to 3; error code: any move touching 2 or 3
				x = (c == 3) || (c == 1 && t == 2) || (c == 2 && t != 0);
				// Settle the tracked state with no sensitivity, then arm the code
				acc(1, 4'h0, 32'h0000_0040);
				if (s) ts <= 2'(t); else rs <= 2'(t);
				w(3); acc(1, 4'h8, 32'h0000_0002); w(3);
				acc(1, 4'h0, 32'h40 | (32'(c) << (s ? 2 : 4)));
				if (s) ts <= 2'(t + 1); else rs <= 2'(t + 1);
				w(3);
				chk({31'h0, irq.error_irq}, {31'h0, x});
				chk({28'h0, tf, rf}, {28'h0, ts, rs});
				if (x) begin
					if (s) ts <= 2'(t); else rs <= 2'(t);
					w(3);
					chk({30'h0, s ? tf : rf}, 32'(t + 1));
				end
			end
		end
		$display("test sensitivity done");
		stop_test();
	end
endmodule : cie_irq_enable_tb
